// >>> umd_defines.svh
// Shared constants for the multidrop serial port
`ifndef UMD_DEFINES_SVH
`define UMD_DEFINES_SVH
`define UMD_OVERSAMPLE     5'h10
`define UMD_OVS_LAST       4'hF
`define UMD_OVS_MID        4'h7
`define UMD_DIV_RESET      16'h0001
`define UMD_FRAME_BITS     4'hA
`define UMD_FRAME_BITS_MP  4'hB
`define UMD_MODE_ALL_ADDR  2'h1
`define UMD_MODE_MATCH     2'h2
`define UMD_MODE_MATCH_NA  2'h3
`endif

// >>> umd_pkg.sv
// Types for the multidrop serial port
package umd_pkg;
  typedef enum logic [1:0] {
    UMD_TX_IDLE  = 2'b00,
    UMD_TX_SETUP = 2'b01,
    UMD_TX_SHIFT = 2'b10
  } umd_tx_state_e;
  typedef enum logic [1:0] {
    UMD_RX_IDLE  = 2'b00,
    UMD_RX_SHIFT = 2'b01
  } umd_rx_state_e;
endpackage : umd_pkg

// >>> umd_tick_if.sv
// Bit-rate tick carrier between generator and port logic
interface umd_tick_if;
  logic        tick;
  logic        reload;
  logic [15:0] divisor;
  modport gen (input divisor, output tick, output reload);
  modport use_side (output divisor, input tick, input reload);
endinterface : umd_tick_if

// >>> umd_brg.sv
// Bit-rate generator: down counter reloading from the divisor
`include "umd_defines.svh"
module umd_brg (
  // Clock and reset
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  // Tick carrier
  umd_tick_if.gen   tk
);
  logic [15:0] cnt;
  logic [15:0] next_cnt;
  logic        tick;
  logic        next_tick;

  always_comb begin
    next_tick = 1'b0;
    next_cnt  = cnt - 16'h0001;
    if (cnt <= `UMD_DIV_RESET) begin
      next_cnt  = (tk.divisor == 16'h0000) ? `UMD_DIV_RESET : tk.divisor;
      next_tick = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      cnt  <= `UMD_DIV_RESET;
      tick <= 1'b0;
    end else begin
      cnt  <= next_cnt;
      tick <= next_tick;
    end
  end

  assign tk.tick   = tick;
  assign tk.reload = tick;
endmodule : umd_brg

// >>> umd_port.sv
// Multidrop serial port: transmitter, receiver, filters, driver enable
// Behaviour
// - In nine-bit mode an address/data flag follows data, before stop bits.
// - Nine-bit mode uses the parity slot as the address/data flag.
// - Address filters act only while multidrop_enable is one.
// - Mode 01: address bytes interrupt, data bytes only with a framing error.
// - Mode 00 with multidrop on: every byte interrupts.
// - rx_addr_flag shows received flag; one marks an address byte.
// - Mode 10: compare address; mismatch drops it and its frame's data.
// - Mode 10: match and following data interrupt; first data sets new_frame_flag.
// - Each later address compares again; mismatch discards until next match.
// - Mode 11 as mode 10 but address bytes raise no interrupt.
// - Drive enable asserts on write, one to two bits before start.
// - Drive enable covers whole frame, releases one clock after last stop.
// - Write once the start bit is out, before frame end, keeps drive enable asserted between frames.
// - drive_enable_polarity selects drive enable sense; default active high.
// - tx_holding_empty and interrupt set after first bit shifts out.
// - Transmit data write clears tx_holding_empty.
// - Receive interrupt on data, break, framing; overrun raises none; data maskable.
// - Overrun keeps held byte and hides overrun/break until it is read.
// - After read, report overrun with data flag; second read clears.
// - With baud interrupt enable, receive interrupt on each generator reload.
// - Divisor is high:low bytes; bit rate is clock over sixteen times it.
// - Both enables off and timer_mode_ctl set: timer interrupts every divisor.
// - Reading receive data with no overrun pending clears data, parity, framing and break flags.
`include "umd_defines.svh"
module umd_port (
  // Clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  // Configuration
  input  wire logic [7:0] div_high_i,
  input  wire logic [7:0] div_low_i,
  input  wire logic       tx_enable_i,
  input  wire logic       rx_enable_i,
  input  wire logic       two_stop_i,
  input  wire logic       parity_en_i,
  input  wire logic       parity_odd_i,
  input  wire logic       multidrop_enable_i,
  input  wire logic [1:0] addr_filter_mode_i,
  input  wire logic [7:0] node_addr_i,
  input  wire logic       drive_enable_polarity_i,
  input  wire logic       rx_data_irq_en_i,
  input  wire logic       brg_irq_en_i,
  input  wire logic       timer_mode_ctl_i,
  // Transmit data port
  input  wire logic       tx_write_i,
  input  wire logic [7:0] tx_data_i,
  input  wire logic       tx_addr_flag_i,
  // Receive data port
  input  wire logic       rx_read_i,
  // Serial pins
  input  wire logic       rxd_i,
  output logic            txd_o,
  output logic            xcvr_drive_enable_o,
  // Status
  output logic [7:0]      rx_data_o,
  output logic            rx_data_avail_o,
  output logic            parity_err_o,
  output logic            overrun_o,
  output logic            framing_err_flag_o,
  output logic            break_seen_o,
  output logic            tx_holding_empty_o,
  output logic            tx_idle_o,
  output logic            rx_addr_flag_o,
  output logic            new_frame_flag_o,
  // Interrupts
  output logic            tx_irq_o,
  output logic            rx_irq_o
);
  // ----------------------------------------------------------------
  // Bit-rate generator
  // ----------------------------------------------------------------
  umd_tick_if tk ();
  assign tk.divisor = {div_high_i, div_low_i};
  umd_brg u_brg (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .tk        (tk.gen)
  );

  logic nine_bit;
  assign nine_bit = multidrop_enable_i;

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  umd_pkg::umd_tx_state_e tx_st, next_tx_st;
  logic [3:0]  tx_ovs, next_tx_ovs;
  logic [3:0]  tx_bit, next_tx_bit;
  logic [3:0]  tx_last, next_tx_last;
  logic [10:0] tx_sh, next_tx_sh;
  logic [7:0]  thr, next_thr;
  logic        thr_flag, next_thr_flag;
  logic        thr_full, next_thr_full;
  logic        de_act, next_de_act;
  logic        tx_pend, next_tx_pend;
  logic        txd, next_txd;
  logic        tx_irq, next_tx_irq;
  logic        tx_ninth;

  // Ninth bit is the address flag in nine-bit mode, else parity
  assign tx_ninth = nine_bit ? thr_flag : (^thr ^ parity_odd_i);

  always_comb begin
    next_tx_st    = tx_st;
    next_tx_ovs   = tx_ovs;
    next_tx_bit   = tx_bit;
    next_tx_last  = tx_last;
    next_tx_sh    = tx_sh;
    next_thr      = thr;
    next_thr_flag = thr_flag;
    next_thr_full = thr_full;
    next_de_act   = de_act;
    next_tx_pend  = 1'b0;
    next_txd      = txd;
    next_tx_irq   = 1'b0;
    if (tx_write_i) begin
      next_thr      = tx_data_i;
      next_thr_flag = tx_addr_flag_i;
      next_thr_full = 1'b1;
      next_de_act   = 1'b1;
    end
    case (tx_st)
      umd_pkg::UMD_TX_IDLE: begin
        next_txd    = 1'b1;
        next_tx_ovs = 4'h0;
        if ((thr_full || tx_write_i) && tx_enable_i) begin
          // Leave on the write edge so setup never exceeds two bits
          next_tx_st  = umd_pkg::UMD_TX_SETUP;
          next_tx_bit = 4'h0;
        end
      end
      umd_pkg::UMD_TX_SETUP: begin
        if (tk.tick) begin
          next_tx_ovs = tx_ovs + 4'h1;
          if (tx_ovs == `UMD_OVS_LAST) begin
            next_tx_bit = tx_bit + 4'h1;
            if (tx_bit != 4'h0) begin
              next_tx_sh    = {1'b1, 1'b1, (nine_bit || parity_en_i) ? tx_ninth : 1'b1, thr};
              next_tx_last  = (nine_bit || parity_en_i) ? (`UMD_FRAME_BITS_MP + {3'h0, two_stop_i} - 4'h1)
                                                        : (`UMD_FRAME_BITS + {3'h0, two_stop_i} - 4'h1);
              next_txd      = 1'b0;
              next_tx_bit   = 4'h0;
              next_tx_st    = umd_pkg::UMD_TX_SHIFT;
            end
          end
        end
      end
      umd_pkg::UMD_TX_SHIFT: begin
        if (tk.tick) begin
          next_tx_ovs = tx_ovs + 4'h1;
          if (tx_ovs == `UMD_OVS_LAST) begin
            next_tx_bit = tx_bit + 4'h1;
            if (tx_bit == 4'h0) begin
              // Holding stays full until the start bit is out
              next_thr_full = tx_write_i;
              next_tx_irq   = 1'b1;
            end
            if (tx_bit == tx_last) begin
              next_txd     = 1'b1;
              next_tx_pend = 1'b1;
              next_tx_st   = umd_pkg::UMD_TX_IDLE;
            end else begin
              next_txd   = tx_sh[0];
              next_tx_sh = {1'b1, tx_sh[10:1]};
            end
          end
        end
      end
      default: next_tx_st = umd_pkg::UMD_TX_IDLE;
    endcase
    // Release one clock after the last stop unless another byte waits
    if (tx_pend && !thr_full && !tx_write_i) begin
      next_de_act = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      tx_st    <= umd_pkg::UMD_TX_IDLE;
      tx_ovs   <= 4'h0;
      tx_bit   <= 4'h0;
      tx_last  <= `UMD_FRAME_BITS;
      tx_sh    <= 11'h7FF;
      thr      <= 8'h00;
      thr_flag <= 1'b0;
      thr_full <= 1'b0;
      de_act   <= 1'b0;
      tx_pend  <= 1'b0;
      txd      <= 1'b1;
      tx_irq   <= 1'b0;
    end else begin
      tx_st    <= next_tx_st;
      tx_ovs   <= next_tx_ovs;
      tx_bit   <= next_tx_bit;
      tx_last  <= next_tx_last;
      tx_sh    <= next_tx_sh;
      thr      <= next_thr;
      thr_flag <= next_thr_flag;
      thr_full <= next_thr_full;
      de_act   <= next_de_act;
      tx_pend  <= next_tx_pend;
      txd      <= next_txd;
      tx_irq   <= next_tx_irq;
    end
  end

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  umd_pkg::umd_rx_state_e rx_st, next_rx_st;
  logic [3:0]  rx_ovs, next_rx_ovs;
  logic [3:0]  rx_bit, next_rx_bit;
  logic [8:0]  rx_sh, next_rx_sh;
  logic [7:0]  rdr, next_rdr;
  logic        rx_data_avail, next_rda;
  logic        pe, next_pe;
  logic        fe, next_fe;
  logic        brk, next_brk;
  logic        ov_hid, next_ov_hid;
  logic        brk_hid, next_brk_hid;
  logic        ov_shown, next_ov_shown;
  logic        addr_f, next_addr_f;
  logic        newfr, next_newfr;
  logic        in_frame, next_in_frame;
  logic        pend_new, next_pend_new;
  logic        rx_irq, next_rx_irq;
  logic [3:0]  rx_nbits;
  logic        is_addr, accept, data_irq, all_zero, match;

  assign rx_nbits = (nine_bit || parity_en_i) ? 4'h9 : 4'h8;

  always_comb begin
    next_rx_st    = rx_st;
    next_rx_ovs   = rx_ovs;
    next_rx_bit   = rx_bit;
    next_rx_sh    = rx_sh;
    next_rdr      = rdr;
    next_rda      = rx_data_avail;
    next_pe       = pe;
    next_fe       = fe;
    next_brk      = brk;
    next_ov_hid   = ov_hid;
    next_brk_hid  = brk_hid;
    next_ov_shown = ov_shown;
    next_addr_f   = addr_f;
    next_newfr    = newfr;
    next_in_frame = in_frame;
    next_pend_new = pend_new;
    next_rx_irq   = 1'b0;
    is_addr  = nine_bit && rx_sh[8];
    match    = (rx_sh[7:0] == node_addr_i);
    all_zero = (rx_sh == 9'h000) && !rxd_i;
    accept   = 1'b1;
    data_irq = 1'b1;
    if (rx_read_i) begin
      if (ov_shown) begin
        next_ov_shown = 1'b0;
        next_rda      = 1'b0;
        next_brk      = 1'b0;
      end else if (ov_hid) begin
        // Held byte read: expose overrun with a byte to discard
        next_ov_shown = 1'b1;
        next_rda      = 1'b1;
        next_brk      = brk_hid;
        next_ov_hid   = 1'b0;
        next_brk_hid  = 1'b0;
      end else begin
        next_rda = 1'b0;
        next_pe  = 1'b0;
        next_fe  = 1'b0;
        next_brk = 1'b0;
      end
    end
    case (rx_st)
      umd_pkg::UMD_RX_IDLE: begin
        next_rx_ovs = 4'h0;
        next_rx_bit = 4'h0;
        if (rx_enable_i && !rxd_i) begin
          next_rx_st = umd_pkg::UMD_RX_SHIFT;
        end
      end
      umd_pkg::UMD_RX_SHIFT: begin
        if (tk.tick) begin
          next_rx_ovs = rx_ovs + 4'h1;
          if (rx_ovs == `UMD_OVS_MID) begin
            next_rx_bit = rx_bit + 4'h1;
            if (rx_bit == 4'h0 && rxd_i) begin
              next_rx_st = umd_pkg::UMD_RX_IDLE; // False start
            end else if (rx_bit != 4'h0 && rx_bit <= rx_nbits) begin
              next_rx_sh = (rx_nbits == 4'h9) ? {rxd_i, rx_sh[8:1]} : {1'b0, rxd_i, rx_sh[7:1]};
            end else if (rx_bit > rx_nbits) begin
              next_rx_st = umd_pkg::UMD_RX_IDLE;
              if (multidrop_enable_i && addr_filter_mode_i != 2'h0) begin
                case (addr_filter_mode_i)
                  `UMD_MODE_ALL_ADDR: begin
                    accept   = is_addr;
                    data_irq = is_addr;
                  end
                  `UMD_MODE_MATCH, `UMD_MODE_MATCH_NA: begin
                    if (is_addr) begin
                      next_in_frame = match;
                      next_pend_new = match;
                      accept        = match;
                      data_irq      = match && (addr_filter_mode_i == `UMD_MODE_MATCH);
                    end else begin
                      accept   = in_frame;
                      data_irq = in_frame;
                    end
                  end
                  default: begin
                    accept   = 1'b1;
                    data_irq = 1'b1;
                  end
                endcase
              end
              if (accept || all_zero || !rxd_i) begin
                if (rx_data_avail && !rx_read_i) begin
                  next_ov_hid  = 1'b1;
                  next_brk_hid = all_zero;
                end else begin
                  next_rdr    = rx_sh[7:0];
                  next_rda    = 1'b1;
                  next_addr_f = rx_sh[8] && nine_bit;
                  next_newfr  = !is_addr && pend_new;
                  if (!is_addr) begin
                    next_pend_new = 1'b0;
                  end
                  next_pe  = parity_en_i && !nine_bit && (^rx_sh ^ parity_odd_i);
                  next_fe  = !rxd_i;
                  next_brk = all_zero;
                  next_rx_irq = (data_irq && rx_data_irq_en_i) || !rxd_i;
                end
              end
            end
          end
        end
      end
      default: next_rx_st = umd_pkg::UMD_RX_IDLE;
    endcase
    // Baud reload doubles as timer interrupt
    if (tk.reload && (brg_irq_en_i ||
        (timer_mode_ctl_i && !tx_enable_i && !rx_enable_i))) begin
      next_rx_irq = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rx_st    <= umd_pkg::UMD_RX_IDLE;
      rx_ovs   <= 4'h0;
      rx_bit   <= 4'h0;
      rx_sh    <= 9'h000;
      rdr      <= 8'h00;
      rx_data_avail      <= 1'b0;
      pe       <= 1'b0;
      fe       <= 1'b0;
      brk      <= 1'b0;
      ov_hid   <= 1'b0;
      brk_hid  <= 1'b0;
      ov_shown <= 1'b0;
      addr_f   <= 1'b0;
      newfr    <= 1'b0;
      in_frame <= 1'b0;
      pend_new <= 1'b0;
      rx_irq   <= 1'b0;
    end else begin
      rx_st    <= next_rx_st;
      rx_ovs   <= next_rx_ovs;
      rx_bit   <= next_rx_bit;
      rx_sh    <= next_rx_sh;
      rdr      <= next_rdr;
      rx_data_avail      <= next_rda;
      pe       <= next_pe;
      fe       <= next_fe;
      brk      <= next_brk;
      ov_hid   <= next_ov_hid;
      brk_hid  <= next_brk_hid;
      ov_shown <= next_ov_shown;
      addr_f   <= next_addr_f;
      newfr    <= next_newfr;
      in_frame <= next_in_frame;
      pend_new <= next_pend_new;
      rx_irq   <= next_rx_irq;
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  logic de_pin;
  logic hold_empty;
  logic tx_idle;
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      de_pin     <= 1'b0;
      hold_empty <= 1'b1;
      tx_idle    <= 1'b1;
    end else begin
      de_pin     <= next_de_act ^ drive_enable_polarity_i;
      hold_empty <= !next_thr_full;
      tx_idle    <= !next_de_act;
    end
  end

  assign txd_o               = txd;
  assign xcvr_drive_enable_o = de_pin;
  assign rx_data_o           = rdr;
  assign rx_data_avail_o     = rx_data_avail;
  assign parity_err_o        = pe;
  assign overrun_o           = ov_shown;
  assign framing_err_flag_o  = fe;
  assign break_seen_o        = brk;
  assign tx_holding_empty_o  = hold_empty;
  assign tx_idle_o           = tx_idle;
  assign rx_addr_flag_o      = addr_f;
  assign new_frame_flag_o    = newfr;
  assign tx_irq_o            = tx_irq;
  assign rx_irq_o            = rx_irq;
endmodule : umd_port

// >>> umd_port_properties.sv
// Concurrent checks on the multidrop serial port pins
module umd_port_properties (
  // Clock and reset
  input wire logic       clk_sys_i,
  input wire logic       rst_n_i,
  // Watched inputs
  input wire logic [7:0] div_high_i,
  input wire logic [7:0] div_low_i,
  input wire logic       tx_enable_i,
  input wire logic       rx_enable_i,
  input wire logic       multidrop_enable_i,
  input wire logic [1:0] addr_filter_mode_i,
  input wire logic       drive_enable_polarity_i,
  input wire logic       timer_mode_ctl_i,
  input wire logic       tx_write_i,
  // Watched outputs
  input wire logic       txd_o,
  input wire logic       xcvr_drive_enable_o,
  input wire logic       tx_holding_empty_o,
  input wire logic       tx_idle_o,
  input wire logic       rx_addr_flag_o,
  input wire logic       rx_irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // ----
  // Timer gap counter
  // ----
  logic        timer_on;
  logic        armed;
  logic [15:0] gap;
  assign timer_on = timer_mode_ctl_i && !tx_enable_i && !rx_enable_i;
  // Armed only after one pulse in timer mode, so the first partial period is skipped
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      gap   <= 16'h0000;
      armed <= 1'b0;
    end else begin
      gap   <= rx_irq_o ? 16'h0000 : gap + 16'h0001;
      armed <= timer_on && (armed || rx_irq_o);
    end
  end
  // ----
  // Properties
  // ----
  a_write_clears_empty: assert property (tx_write_i |=> !tx_holding_empty_o)
    else $error("holding empty not cleared by write");
  a_drive_on_write: assert property (tx_write_i && tx_idle_o && tx_enable_i && !drive_enable_polarity_i
    |-> ##[1:2] xcvr_drive_enable_o) else $error("drive enable late after write");
  a_drive_setup_time: assert property ($fell(txd_o) && !drive_enable_polarity_i
    |-> $past(xcvr_drive_enable_o, 16)) else $error("drive enable setup below one bit");
  a_drive_setup_max: assert property ($rose(xcvr_drive_enable_o) && !drive_enable_polarity_i &&
    {div_high_i, div_low_i} == 16'h0001 |-> ##[16:32] $fell(txd_o)) else $error("drive enable setup above two bits");
  a_drive_covers_frame: assert property (!txd_o |-> xcvr_drive_enable_o != drive_enable_polarity_i)
    else $error("drive enable inactive during frame");
  a_drive_release_stop: assert property ($fell(xcvr_drive_enable_o) && !drive_enable_polarity_i
    |-> $past(txd_o) && $past(txd_o, 16)) else $error("drive enable released inside frame");
  a_idle_drive_sense: assert property (tx_idle_o && $past(tx_idle_o) && $stable(drive_enable_polarity_i)
    |-> xcvr_drive_enable_o == drive_enable_polarity_i) else $error("idle drive enable sense wrong");
  a_mode01_addr_only: assert property (multidrop_enable_i && addr_filter_mode_i == 2'h1 && rx_irq_o
    |-> ##[0:1] rx_addr_flag_o) else $error("data byte interrupted in mode 01");
  a_timer_interval: assert property (timer_on && armed && rx_irq_o
    |-> gap == {div_high_i, div_low_i} - 16'h0001) else $error("timer interval wrong");
endmodule : umd_port_properties

bind umd_port umd_port_properties umd_port_properties_inst (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .div_high_i(div_high_i), .div_low_i(div_low_i),
  .tx_enable_i(tx_enable_i), .rx_enable_i(rx_enable_i), .multidrop_enable_i(multidrop_enable_i),
  .addr_filter_mode_i(addr_filter_mode_i), .drive_enable_polarity_i(drive_enable_polarity_i),
  .timer_mode_ctl_i(timer_mode_ctl_i), .tx_write_i(tx_write_i), .txd_o(txd_o),
  .xcvr_drive_enable_o(xcvr_drive_enable_o), .tx_holding_empty_o(tx_holding_empty_o),
  .tx_idle_o(tx_idle_o), .rx_addr_flag_o(rx_addr_flag_o), .rx_irq_o(rx_irq_o)
);

// >>> umd_node_model.sv
// Far node on the shared serial line
module umd_node_model #(
  parameter int BIT_CLKS = 16
) (
  input  wire logic clk_sys_i,
  input  wire logic txd_i,
  output logic      rxd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Bus bias holds the idle line at mark
  initial rxd_o = 1'b1;
  task automatic send_char(input logic [7:0] data, input logic flag, input logic stop_ok);
    logic [10:0] frame;
    frame = {stop_ok, flag, data, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rxd_o <= frame[i];
      repeat (BIT_CLKS) @(posedge clk_sys_i);
    end
    rxd_o <= 1'b1;
    @(posedge clk_sys_i);
  endtask : send_char
  // Mid-bit sampling leaves margin for the registered pin
  task automatic get_char(output logic [7:0] data, output logic flag);
    while (txd_i !== 1'b0) @(posedge clk_sys_i);
    repeat (BIT_CLKS / 2) @(posedge clk_sys_i);
    for (int i = 0; i < 9; i++) begin
      repeat (BIT_CLKS) @(posedge clk_sys_i);
      if (i < 8) data[i] = txd_i;
      else flag = txd_i;
    end
  endtask : get_char
endmodule : umd_node_model

// >>> tb_top.sv
// Self-checking bench for the multidrop serial port
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // Stimulus and observation
  // ----
  logic       clk_sys_i = 1'b0;
  logic       rst_n_i   = 1'b0;
  logic [7:0] div_lo    = 8'h01;
  logic       tx_en     = 1'b1;
  logic       rx_en     = 1'b1;
  logic       mp        = 1'b1;
  logic [1:0] mode      = 2'h0;
  logic       pol       = 1'b0;
  logic       rda_ie    = 1'b1;
  logic       brg_ie    = 1'b0;
  logic       timer     = 1'b0;
  logic       wr        = 1'b0;
  logic [7:0] wdat      = 8'h00;
  logic       wflag     = 1'b0;
  logic       rd        = 1'b0;
  logic       rxd, txd, de, rx_data_avail, ovr, fe, brk, empty, idle, raf, nff, tirq, rirq;
  logic [7:0] rdat;
  logic [7:0] got_d [2];
  logic       got_f [2];
  logic [7:0] bytes [4] = '{8'h5A, 8'h11, 8'hDA, 8'h22};
  logic [3:0] flags     = 4'b0101;
  logic [3:0] exp_irq [5] = '{4'b1111, 4'b0101, 4'b0011, 4'b0010, 4'b1111};
  int         bad_count = 0;
  int         tests_run = 0;
  int         irq_cnt   = 0;
  int         base, n, gaps;
  umd_port umd_port_inst (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .div_high_i(8'h00), .div_low_i(div_lo),
    .tx_enable_i(tx_en), .rx_enable_i(rx_en), .two_stop_i(1'b0), .parity_en_i(1'b0),
    .parity_odd_i(1'b0), .multidrop_enable_i(mp), .addr_filter_mode_i(mode), .node_addr_i(8'h5A),
    .drive_enable_polarity_i(pol), .rx_data_irq_en_i(rda_ie), .brg_irq_en_i(brg_ie),
    .timer_mode_ctl_i(timer), .tx_write_i(wr), .tx_data_i(wdat), .tx_addr_flag_i(wflag),
    .rx_read_i(rd), .rxd_i(rxd), .txd_o(txd), .xcvr_drive_enable_o(de), .rx_data_o(rdat),
    .rx_data_avail_o(rx_data_avail), .parity_err_o(), .overrun_o(ovr), .framing_err_flag_o(fe),
    .break_seen_o(brk), .tx_holding_empty_o(empty), .tx_idle_o(idle), .rx_addr_flag_o(raf),
    .new_frame_flag_o(nff), .tx_irq_o(tirq), .rx_irq_o(rirq)
  );
  umd_node_model umd_node_model_inst (.clk_sys_i(clk_sys_i), .txd_i(txd), .rxd_o(rxd));
  initial begin
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) if (rirq === 1'b1) irq_cnt <= irq_cnt + 1;
  // ----
  // Access and compare tasks
  // ----
  task automatic write_tx(input logic [7:0] d, input logic f);
    wdat  <= d;
    wflag <= f;
    wr    <= 1'b1;
    @(posedge clk_sys_i);
    wr <= 1'b0;
  endtask : write_tx
  task automatic read_rx;
    rd <= 1'b1;
    @(posedge clk_sys_i);
    rd <= 1'b0;
    @(posedge clk_sys_i);
  endtask : read_rx
  task automatic check1(input string what, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask : check1
  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check8
  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim
  // Whole run is near 5000 cycles
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    bad_count++;
    end_sim;
  end
  // ----
  // Scenarios
  // ----
  initial begin
    repeat (6) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    fork
      begin
        umd_node_model_inst.get_char(got_d[0], got_f[0]);
        umd_node_model_inst.get_char(got_d[1], got_f[1]);
      end
    join_none
    write_tx(8'hA5, 1'b1);
    repeat (2) @(negedge clk_sys_i);
    check1("holding_empty", 1'b0, empty);
    repeat (2) @(negedge clk_sys_i);
    check1("drive_setup", 1'b1, de & txd);
    n = 0;
    while (tirq !== 1'b1 && n < 400) begin
      @(negedge clk_sys_i);
      n++;
    end
    check1("tx_irq", 1'b1, tirq);
    check1("empty_at_irq", 1'b1, empty);
    @(posedge clk_sys_i);
    write_tx(8'h3C, 1'b0);
    gaps = 0;
    n = 0;
    while (idle !== 1'b1 && n < 600) begin
      @(negedge clk_sys_i);
      gaps += int'(idle !== 1'b1 && de !== 1'b1);
      n++;
    end
    check8("char0", 8'hA5, got_d[0]);
    check1("flag0", 1'b1, got_f[0]);
    check8("char1", 8'h3C, got_d[1]);
    check1("flag1", 1'b0, got_f[1]);
    check8("drive_gaps", 8'h00, 8'(gaps));
    check1("empty_idle", 1'b1, empty);
    @(posedge clk_sys_i);
    pol <= 1'b1;
    repeat (3) @(negedge clk_sys_i);
    check1("drive_inactive", 1'b1, de);
    @(posedge clk_sys_i);
    pol <= 1'b0;
    // Row four has filtering off: every byte interrupts, bad stops as framing errors
    for (int m = 0; m < 5; m++) begin
      @(posedge clk_sys_i);
      mp   <= (m < 4);
      mode <= (m < 4) ? m[1:0] : 2'h2;
      for (int k = 0; k < 4; k++) begin
        base = irq_cnt;
        umd_node_model_inst.send_char(bytes[k], flags[k], 1'b1);
        repeat (3) @(negedge clk_sys_i);
        check8("rx_irqs", {7'h00, exp_irq[m][k]}, 8'(irq_cnt - base));
        if (exp_irq[m][k] && m < 4) begin
          check8("rx_data", bytes[k], rdat);
          check1("rx_addr_flag", flags[k], raf);
        end
        if ((m == 2 || m == 3) && k == 1) check1("new_frame", 1'b1, nff);
        @(posedge clk_sys_i);
        if (rx_data_avail === 1'b1) read_rx;
      end
    end
    @(posedge clk_sys_i);
    mp   <= 1'b1;
    mode <= 2'h0;
    umd_node_model_inst.send_char(8'h11, 1'b0, 1'b1);
    umd_node_model_inst.send_char(8'h22, 1'b0, 1'b1);
    @(negedge clk_sys_i);
    check8("held_data", 8'h11, rdat);
    check1("overrun_hidden", 1'b0, ovr);
    @(posedge clk_sys_i);
    read_rx;
    @(negedge clk_sys_i);
    check1("overrun_shown", 1'b1, ovr & rx_data_avail);
    @(posedge clk_sys_i);
    read_rx;
    @(negedge clk_sys_i);
    check1("overrun_cleared", 1'b0, ovr | rx_data_avail);
    @(posedge clk_sys_i);
    base = irq_cnt;
    umd_node_model_inst.send_char(8'h00, 1'b0, 1'b0);
    repeat (3) @(negedge clk_sys_i);
    check1("break_seen", 1'b1, brk & fe);
    check8("break_irqs", 8'h01, 8'(irq_cnt - base));
    @(posedge clk_sys_i);
    read_rx;
    @(negedge clk_sys_i);
    check1("errors_cleared", 1'b0, brk | fe | rx_data_avail);
    @(posedge clk_sys_i);
    rda_ie <= 1'b0;
    base = irq_cnt;
    umd_node_model_inst.send_char(8'h77, 1'b0, 1'b1);
    repeat (3) @(negedge clk_sys_i);
    check8("masked_irqs", 8'h00, 8'(irq_cnt - base));
    check1("masked_avail", 1'b1, rx_data_avail);
    @(posedge clk_sys_i);
    read_rx;
    tx_en  <= 1'b0;
    rx_en  <= 1'b0;
    div_lo <= 8'h04;
    repeat (8) @(posedge clk_sys_i);
    timer <= 1'b1;
    repeat (8) @(posedge clk_sys_i);
    base = irq_cnt;
    repeat (40) @(posedge clk_sys_i);
    check8("timer_irqs", 8'h0A, 8'(irq_cnt - base));
    timer  <= 1'b0;
    brg_ie <= 1'b1;
    repeat (8) @(posedge clk_sys_i);
    base = irq_cnt;
    repeat (40) @(posedge clk_sys_i);
    check8("reload_irqs", 8'h0A, 8'(irq_cnt - base));
    end_sim;
  end
endmodule : tb_top
